// [rtl/converter_ctrl_map.svh]
/*
 * Offsets, field positions, reset values and register widths of the
 * buck/boost converter control registers.
 * Assumes it is included by bare name; definitions only.
 */
`ifndef CONVERTER_CTRL_MAP_SVH
`define CONVERTER_CTRL_MAP_SVH

// ----------------------------------------------------------------------
// Register offsets (byte addresses, 16-bit registers)
// ----------------------------------------------------------------------
`define CONV_ADDR_W 32
`define CONV_DATA_W 16
`define CONV_CTRL_ONE_ADDR 32'h5000_0080
`define CONV_CTRL_TWO_ADDR 32'h5000_0082
`define CONV_CTRL_THREE_ADDR 32'h5000_0084

// ----------------------------------------------------------------------
// Control one fields
// ----------------------------------------------------------------------
`define CONV_TUNE_HI 15
`define CONV_TUNE_LO 14
`define CONV_OSW_HI 13
`define CONV_OSW_LO 12
`define CONV_PSW_HI 11
`define CONV_PSW_LO 10
`define CONV_NSW_HI 9
`define CONV_NSW_LO 8
`define CONV_TEST_HI 7
`define CONV_TEST_LO 5
`define CONV_SPARE1_BIT 4
`define CONV_LOWTH_HI 3
`define CONV_LOWTH_LO 1
`define CONV_SPARE0_BIT 0

// ----------------------------------------------------------------------
// Control two fields
// ----------------------------------------------------------------------
`define CONV_VOUT_HI 15
`define CONV_VOUT_LO 12
`define CONV_BOOST_HI 11
`define CONV_BOOST_LO 9
`define CONV_TON_HI 8
`define CONV_TON_LO 7
`define CONV_ILIM_HI 6
`define CONV_ILIM_LO 3
`define CONV_CAL_HI 2
`define CONV_CAL_LO 0

// ----------------------------------------------------------------------
// Control three fields
// ----------------------------------------------------------------------
`define CONV_TMO_HI 4
`define CONV_TMO_LO 3
`define CONV_IDLE_HI 2
`define CONV_IDLE_LO 1
`define CONV_BUCK_BIT 0

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define CONV_CTRL_ONE_RST 16'h000C
`define CONV_CTRL_TWO_RST 16'h8C20
`define CONV_CTRL_THREE_RST 16'h0015
`define CONV_CTRL_THREE_MASK 16'h001F
`define CONV_READ_ZERO 16'h0000
`define CONV_BOOST_RST 3'h6
`define CONV_SYNC_RST 2'h0
`define CONV_SLOW_RST 1'b1

`endif

// [rtl/converter_ctrl_pkg.sv]
/*
 * Types for the buck/boost converter control registers.
 * Assumes the map header for field positions.
 */
`default_nettype none

package converter_ctrl_pkg;

    // Drive-strength encoding shared by all three switches
    typedef enum logic [1:0] {
        DRIVE_FULL = 2'h0,
        DRIVE_TWO_THIRDS = 2'h1,
        DRIVE_ONE_THIRD = 2'h2,
        DRIVE_OFF = 2'h3
    } drive_level_t;

    // Idle-check trigger clock selection
    typedef enum logic [1:0] {
        IDLE_16MHZ = 2'h0,
        IDLE_4MHZ = 2'h1,
        IDLE_1MHZ = 2'h2,
        IDLE_250KHZ = 2'h3
    } idle_clock_t;

    // Whole state of the register bank
    typedef struct packed {
        logic [15:0] ctrlOne;
        logic [15:0] ctrlTwo;
        logic [15:0] ctrlThree;
        logic [15:0] readData;
        logic [1:0] otpSync;
        logic [1:0] oscSync;
        logic [2:0] boostCode;
        logic useSlowTrigger;
    } bank_state_t;

endpackage

`default_nettype wire

// [rtl/buck_boost_control_regs.sv]
/*
 * Register bank for the on-chip buck/boost converter: three 16-bit
 * read/write control registers whose fields drive the analog converter.
 * Assumes a plain strobe bus on sys_clk; status levels from the oscillator
 * and OTP regulator logic arrive asynchronously and are synchronised here.
 *
 * Control one fields:
 *   15:14 senseTune, trim for the current-sense path
 *   13:12 output_switch_drive
 *   11:10 supply_switch_drive
 *   9:8   ground_switch_drive
 *   7:5   testMode, no function outside test
 *   4     spare, stored and read back
 *   3:1   low_input_threshold
 *   0     spare, stored and read back
 * Control two fields:
 *   15:12 converter_output_code
 *   11:9  boost_output_code, top bit forced by regulator status
 *   8:7   min_on_time
 *   6:3   switch_current_limit
 *   2:0   autoCalibration, zero turns calibration off
 * Control three fields:
 *   15:5  no storage, read as zero
 *   4:3   converterTimeout
 *   2:1   idleTriggerSelect
 *   0     buckEnable
 * Status level changes take three edges to reach an output.
 * Read data stands for the one cycle after the strobe, zero otherwise.
 */
// Summary of operation
// (R1) Three 2-bit switch drive fields: full, two-thirds, one-third, off.
// (R2) Two-bit tune field at top of control one, reset zero, forwarded.
// (R3) Three-bit low input threshold disabling boost, reset 0x6.
// (R4) Four-bit converter output code in bits 15:12, reset 0x8.
// (R5) Three-bit boost output code in bits 11:9, reset 0x6.
// (R6) Boost code MSB forced high while OTP regulator is enabled.
// (R7) Two-bit minimum on-time field, reset zero; software picks 2 or 1.
// (R8) Four-bit switch current limit field, reset 0x4.
// (R9) Three-bit calibration field; zero disables, reset zero.
// (R10) Two-bit idle trigger clock select, reset 0x2.
// (R11) Slow 32 kHz trigger used whenever no 16 MHz oscillator runs.
// (R12) Buck enable bit 0 of control three, reset one.
// (R13) Two-bit timeout field bits 4:3, reset 0x2, passed through.
// (R14) All fields read back as written except the forced boost MSB; unused bits reset zero.
`timescale 1ns/100ps
`include "converter_ctrl_map.svh"
`default_nettype none

module buck_boost_control_regs (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic resetn,
    // Register port
    input wire logic [`CONV_ADDR_W-1:0] regAddr,
    input wire logic [`CONV_DATA_W-1:0] regWriteData,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [`CONV_DATA_W-1:0] regReadData,
    // Asynchronous status from the surrounding system
    input wire logic otpRegulatorOn,
    input wire logic fastOscActive,
    // Control one outputs
    output logic [1:0] senseTune,
    output logic [1:0] output_switch_drive,
    output logic [1:0] supply_switch_drive,
    output logic [1:0] ground_switch_drive,
    output logic [2:0] testMode,
    output logic [2:0] low_input_threshold,
    // Control two outputs
    output logic [3:0] converter_output_code,
    output logic [2:0] boost_output_code,
    output logic [1:0] min_on_time,
    output logic [3:0] switch_current_limit,
    output logic [2:0] autoCalibration,
    // Control three outputs
    output logic [1:0] converterTimeout,
    output logic [1:0] idleTriggerSelect,
    output logic useSlowIdleTrigger,
    output logic buckEnable
);

    // ------------------------------------------------------------------
    // Register bank state, synchroniser stages included
    // ------------------------------------------------------------------
    converter_ctrl_pkg::bank_state_t state_reg;
    converter_ctrl_pkg::bank_state_t state_next;

    // Next-state: synchronisers, writes, read data and derived levels
    always_comb begin
        state_next = state_reg;
        state_next.readData = `CONV_READ_ZERO;

        // Two stages per status level; only the second feeds any logic
        state_next.otpSync = {state_reg.otpSync[0], otpRegulatorOn};
        state_next.oscSync = {state_reg.oscSync[0], fastOscActive};

        // Slow trigger whenever the fast oscillator is seen stopped
        state_next.useSlowTrigger = ~state_reg.oscSync[1]; // R11

        // Register writes, field by field, whole 16-bit words only
        if (regWrite) begin
            unique case (regAddr)
                `CONV_CTRL_ONE_ADDR: begin
                    state_next.ctrlOne[`CONV_TUNE_HI:`CONV_TUNE_LO] =
                        regWriteData[`CONV_TUNE_HI:`CONV_TUNE_LO]; // R2
                    state_next.ctrlOne[`CONV_OSW_HI:`CONV_OSW_LO] =
                        regWriteData[`CONV_OSW_HI:`CONV_OSW_LO]; // R1
                    state_next.ctrlOne[`CONV_PSW_HI:`CONV_PSW_LO] =
                        regWriteData[`CONV_PSW_HI:`CONV_PSW_LO]; // R1
                    state_next.ctrlOne[`CONV_NSW_HI:`CONV_NSW_LO] =
                        regWriteData[`CONV_NSW_HI:`CONV_NSW_LO]; // R1
                    state_next.ctrlOne[`CONV_TEST_HI:`CONV_TEST_LO] =
                        regWriteData[`CONV_TEST_HI:`CONV_TEST_LO]; // R14
                    state_next.ctrlOne[`CONV_SPARE1_BIT] =
                        regWriteData[`CONV_SPARE1_BIT]; // R14
                    state_next.ctrlOne[`CONV_LOWTH_HI:`CONV_LOWTH_LO] =
                        regWriteData[`CONV_LOWTH_HI:`CONV_LOWTH_LO]; // R3
                    state_next.ctrlOne[`CONV_SPARE0_BIT] =
                        regWriteData[`CONV_SPARE0_BIT]; // R14
                end
                `CONV_CTRL_TWO_ADDR: begin
                    state_next.ctrlTwo[`CONV_VOUT_HI:`CONV_VOUT_LO] =
                        regWriteData[`CONV_VOUT_HI:`CONV_VOUT_LO]; // R4
                    // Stored boost bits stay as written, force or not
                    state_next.ctrlTwo[`CONV_BOOST_HI:`CONV_BOOST_LO] =
                        regWriteData[`CONV_BOOST_HI:`CONV_BOOST_LO]; // R5
                    state_next.ctrlTwo[`CONV_TON_HI:`CONV_TON_LO] =
                        regWriteData[`CONV_TON_HI:`CONV_TON_LO]; // R7
                    state_next.ctrlTwo[`CONV_ILIM_HI:`CONV_ILIM_LO] =
                        regWriteData[`CONV_ILIM_HI:`CONV_ILIM_LO]; // R8
                    state_next.ctrlTwo[`CONV_CAL_HI:`CONV_CAL_LO] =
                        regWriteData[`CONV_CAL_HI:`CONV_CAL_LO]; // R9
                end
                `CONV_CTRL_THREE_ADDR: begin
                    // Upper bits have no storage and read as zero
                    state_next.ctrlThree = `CONV_READ_ZERO;
                    state_next.ctrlThree[`CONV_TMO_HI:`CONV_TMO_LO] =
                        regWriteData[`CONV_TMO_HI:`CONV_TMO_LO]; // R13
                    state_next.ctrlThree[`CONV_IDLE_HI:`CONV_IDLE_LO] =
                        regWriteData[`CONV_IDLE_HI:`CONV_IDLE_LO]; // R10
                    state_next.ctrlThree[`CONV_BUCK_BIT] =
                        regWriteData[`CONV_BUCK_BIT]; // R12
                end
                default: begin
                    // Unmapped writes are ignored
                end
            endcase
        end

        // Boost code gets a flop of its own so the pin is glitch free;
        // the top bit is forced while the regulator status is high
        state_next.boostCode =
            state_next.ctrlTwo[`CONV_BOOST_HI:`CONV_BOOST_LO]; // R5
        if (state_reg.otpSync[1]) begin
            state_next.boostCode[2] = 1'b1; // R6
        end

        // Read data for the cycle after the strobe
        if (regRead) begin
            unique case (regAddr)
                `CONV_CTRL_ONE_ADDR: begin
                    state_next.readData = state_reg.ctrlOne; // R14
                end
                `CONV_CTRL_TWO_ADDR: begin
                    // Software sees the code the converter really gets
                    state_next.readData = state_reg.ctrlTwo; // R14
                    state_next.readData[`CONV_BOOST_HI:`CONV_BOOST_LO] =
                        state_reg.boostCode; // R6
                end
                `CONV_CTRL_THREE_ADDR: begin
                    state_next.readData = state_reg.ctrlThree; // R14
                end
                default: begin
                    state_next.readData = `CONV_READ_ZERO;
                end
            endcase
        end
    end

    // Bank register; every reset value is a constant
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            state_reg.ctrlOne <= `CONV_CTRL_ONE_RST; // R2 R3
            state_reg.ctrlTwo <= `CONV_CTRL_TWO_RST; // R4 R5 R7 R8 R9
            state_reg.ctrlThree <= `CONV_CTRL_THREE_RST; // R10 R12 R13
            state_reg.readData <= `CONV_READ_ZERO;
            state_reg.otpSync <= `CONV_SYNC_RST;
            state_reg.oscSync <= `CONV_SYNC_RST;
            state_reg.boostCode <= `CONV_BOOST_RST; // R5
            state_reg.useSlowTrigger <= `CONV_SLOW_RST; // R11
        end else begin
            state_reg <= state_next;
        end
    end

    // ------------------------------------------------------------------
    // Outputs to the analog converter
    // ------------------------------------------------------------------
    // Fields are slices of flip-flops; forced MSB comes from a flop too
    assign regReadData = state_reg.readData;
    assign senseTune = state_reg.ctrlOne[`CONV_TUNE_HI:`CONV_TUNE_LO]; // R2
    assign output_switch_drive =
        state_reg.ctrlOne[`CONV_OSW_HI:`CONV_OSW_LO]; // R1
    assign supply_switch_drive =
        state_reg.ctrlOne[`CONV_PSW_HI:`CONV_PSW_LO]; // R1
    assign ground_switch_drive =
        state_reg.ctrlOne[`CONV_NSW_HI:`CONV_NSW_LO]; // R1
    assign testMode = state_reg.ctrlOne[`CONV_TEST_HI:`CONV_TEST_LO];
    assign low_input_threshold =
        state_reg.ctrlOne[`CONV_LOWTH_HI:`CONV_LOWTH_LO]; // R3
    assign converter_output_code =
        state_reg.ctrlTwo[`CONV_VOUT_HI:`CONV_VOUT_LO]; // R4
    assign boost_output_code = state_reg.boostCode; // R5 R6
    assign min_on_time = state_reg.ctrlTwo[`CONV_TON_HI:`CONV_TON_LO]; // R7
    assign switch_current_limit =
        state_reg.ctrlTwo[`CONV_ILIM_HI:`CONV_ILIM_LO]; // R8
    assign autoCalibration =
        state_reg.ctrlTwo[`CONV_CAL_HI:`CONV_CAL_LO]; // R9
    assign converterTimeout =
        state_reg.ctrlThree[`CONV_TMO_HI:`CONV_TMO_LO]; // R13
    assign idleTriggerSelect =
        state_reg.ctrlThree[`CONV_IDLE_HI:`CONV_IDLE_LO]; // R10
    assign useSlowIdleTrigger = state_reg.useSlowTrigger; // R11
    assign buckEnable = state_reg.ctrlThree[`CONV_BUCK_BIT]; // R12

endmodule // buck_boost_control_regs

`default_nettype wire

// [dv/converter_checker.sv]
/* Concurrent checks on the converter register bank ports.
   Assumes the map header and the single sys_clk domain. */
`timescale 1ns/100ps
`include "converter_ctrl_map.svh"
`default_nettype none
module converter_checker (
    // Clock, reset and bus
    input wire logic sys_clk, resetn, regWrite, regRead,
    input wire logic [31:0] regAddr,
    input wire logic [15:0] regWriteData, regReadData,
    // Status and fields
    input wire logic otpRegulatorOn, fastOscActive, useSlowIdleTrigger,
    input wire logic [1:0] senseTune, min_on_time, converterTimeout,
    input wire logic [1:0] idleTriggerSelect,
    input wire logic [2:0] low_input_threshold, boost_output_code,
    input wire logic [2:0] autoCalibration,
    input wire logic [3:0] converter_output_code, switch_current_limit,
    input wire logic buckEnable
);
    // ------------------------------------------------------------
    // Properties, one clock domain
    // ------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);
    property p_read_idle; !$past(regRead) |-> regReadData == 16'h0000;
    endproperty
    a_read_idle: assert property (p_read_idle)
        else $error("read data not zero outside read cycle");
    property p_read_one; $past(regRead && regAddr == `CONV_CTRL_ONE_ADDR)
        |-> {regReadData[15:14], regReadData[3:1]} ==
            {senseTune, low_input_threshold}; endproperty
    a_read_one: assert property (p_read_one)
        else $error("control one read differs from fields");
    property p_read_two; $past(regRead && regAddr == `CONV_CTRL_TWO_ADDR)
        |-> {regReadData[15:12], regReadData[8:0]} == {converter_output_code,
            min_on_time, switch_current_limit, autoCalibration}; endproperty
    a_read_two: assert property (p_read_two)
        else $error("control two read differs from fields");
    property p_read_three; $past(regRead && regAddr == `CONV_CTRL_THREE_ADDR)
        |-> regReadData == {11'h000, converterTimeout, idleTriggerSelect,
            buckEnable}; endproperty
    a_read_three: assert property (p_read_three)
        else $error("control three read differs from fields");
    property p_write_two; regWrite && regAddr == `CONV_CTRL_TWO_ADDR |=>
        {min_on_time, switch_current_limit, autoCalibration} ==
        $past(regWriteData[8:0]) &&
        converter_output_code == $past(regWriteData[15:12]); endproperty
    a_write_two: assert property (p_write_two)
        else $error("on-time or calibration not taken from write");
    // Unmapped writes must leave the seven watched stored fields alone
    property p_unmapped; regWrite && !(regAddr inside {`CONV_CTRL_ONE_ADDR,
        `CONV_CTRL_TWO_ADDR, `CONV_CTRL_THREE_ADDR}) |=> $stable({senseTune,
        low_input_threshold, converter_output_code, switch_current_limit,
        converterTimeout, idleTriggerSelect, buckEnable}); endproperty
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped write changed a field");
    // Sync stages need three edges, so five held samples are ample
    property p_force; otpRegulatorOn [*5] |-> boost_output_code[2];
    endproperty
    a_force: assert property (p_force)
        else $error("boost code top bit not forced");
    property p_slow; $stable(fastOscActive) [*5] |->
        useSlowIdleTrigger == !fastOscActive; endproperty
    a_slow: assert property (p_slow)
        else $error("idle trigger fallback wrong");
endmodule // converter_checker
bind buck_boost_control_regs converter_checker u_checker (
    .sys_clk(sys_clk), .resetn(resetn), .regWrite(regWrite),
    .regRead(regRead), .regAddr(regAddr), .regWriteData(regWriteData),
    .regReadData(regReadData), .otpRegulatorOn(otpRegulatorOn),
    .fastOscActive(fastOscActive), .useSlowIdleTrigger(useSlowIdleTrigger),
    .senseTune(senseTune), .min_on_time(min_on_time),
    .converterTimeout(converterTimeout), .buckEnable(buckEnable),
    .idleTriggerSelect(idleTriggerSelect), .autoCalibration(autoCalibration),
    .low_input_threshold(low_input_threshold),
    .boost_output_code(boost_output_code),
    .converter_output_code(converter_output_code),
    .switch_current_limit(switch_current_limit));
`default_nettype wire

// [dv/converter_model.sv]
/* Far-side model: supply status levels seen by the register bank.
   Assumes the bench requests each condition; levels move off the clock. */
`timescale 1ns/100ps
`default_nettype none
module converter_model (
    // Requested conditions
    input wire logic otpWanted,
    input wire logic oscWanted,
    // Status levels
    output logic otpRegulatorOn,
    output logic fastOscActive
);
    // Odd delays keep the levels unrelated to the clock phase
    initial otpRegulatorOn = 1'b0;
    initial fastOscActive = 1'b1;
    always @(otpWanted) otpRegulatorOn <= #37 otpWanted;
    always @(oscWanted) fastOscActive <= #23 oscWanted;
endmodule // converter_model
`default_nettype wire

// [dv/testbench.sv]
/* Self-checking bench for the converter register bank.
   Assumes the strobe bus of the bank and the status model. */
`timescale 1ns/100ps
`include "converter_ctrl_map.svh"
`default_nettype none
module testbench;
    // Stimulus and observed signals
    logic sys_clk = 1'b0, resetn = 1'b0, regWrite = 1'b0, regRead = 1'b0;
    logic otpWanted = 1'b0, oscWanted = 1'b1;
    logic [31:0] regAddr = 32'h0000_0000;
    logic [15:0] regWriteData = 16'h0000, regReadData;
    logic otpRegulatorOn, fastOscActive, useSlowIdleTrigger, buckEnable;
    logic [1:0] senseTune, output_switch_drive, supply_switch_drive;
    logic [1:0] ground_switch_drive, min_on_time, converterTimeout;
    logic [1:0] idleTriggerSelect;
    logic [2:0] testMode, low_input_threshold, boost_output_code;
    logic [2:0] autoCalibration;
    logic [3:0] converter_output_code, switch_current_limit;
    int numErrors = 0, comparisons = 0;
    buck_boost_control_regs DUT (.sys_clk(sys_clk), .resetn(resetn),
        .regAddr(regAddr), .regWriteData(regWriteData), .regWrite(regWrite),
        .regRead(regRead), .regReadData(regReadData),
        .otpRegulatorOn(otpRegulatorOn), .fastOscActive(fastOscActive),
        .senseTune(senseTune), .output_switch_drive(output_switch_drive),
        .supply_switch_drive(supply_switch_drive), .testMode(testMode),
        .ground_switch_drive(ground_switch_drive),
        .low_input_threshold(low_input_threshold),
        .converter_output_code(converter_output_code),
        .boost_output_code(boost_output_code), .min_on_time(min_on_time),
        .switch_current_limit(switch_current_limit),
        .autoCalibration(autoCalibration), .buckEnable(buckEnable),
        .converterTimeout(converterTimeout),
        .idleTriggerSelect(idleTriggerSelect),
        .useSlowIdleTrigger(useSlowIdleTrigger));
    converter_model u_model (.otpWanted(otpWanted), .oscWanted(oscWanted),
        .otpRegulatorOn(otpRegulatorOn), .fastOscActive(fastOscActive));
    // ------------------------------------------------------------
    // Bus tasks
    // ------------------------------------------------------------
    initial forever #25 sys_clk = ~sys_clk;
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            numErrors++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [31:0] a, input logic [15:0] d);
        @(posedge sys_clk);
        regWrite <= 1'b1;
        regAddr <= a;
        regWriteData <= d;
        @(posedge sys_clk);
        regWrite <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [31:0] a, input logic [15:0] exp);
        @(posedge sys_clk);
        regRead <= 1'b1;
        regAddr <= a;
        @(posedge sys_clk);
        regRead <= 1'b0;
        #1;
        check(regReadData, exp);
    endtask
    // Reset held four cycles, then every reset value read back
    task automatic reset_and_defaults;
        resetn <= 1'b0;
        repeat (4) @(posedge sys_clk);
        resetn <= 1'b1;
        rd(`CONV_CTRL_ONE_ADDR, 16'h000C);
        rd(`CONV_CTRL_TWO_ADDR, 16'h8C20);
        rd(`CONV_CTRL_THREE_ADDR, 16'h0015);
    endtask
    task automatic summarize;
        $display("errors=%0d comparisons=%0d", numErrors, comparisons);
        if (numErrors == 0 && comparisons > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial begin
        logic [15:0] d;
        logic [2:0] th [4];
        th = '{3'h6, 3'h5, 3'h3, 3'h7};
        reset_and_defaults();
        // Same code in every 2-bit field, then read back
        for (int i = 0; i < 4; i++) begin
            d = 16'(16'h5555 * i);
            wr(`CONV_CTRL_ONE_ADDR, d);
            check(16'({output_switch_drive, supply_switch_drive,
                ground_switch_drive}), 16'(i * 21));
            check(16'(testMode), 16'(d[7:5]));
            wr(`CONV_CTRL_THREE_ADDR, d);
            check(16'(idleTriggerSelect), 16'(d[2:1]));
            wr(`CONV_CTRL_TWO_ADDR, d);
            rd(`CONV_CTRL_ONE_ADDR, d);
            rd(`CONV_CTRL_TWO_ADDR, d);
            rd(`CONV_CTRL_THREE_ADDR, d & 16'h001F);
        end
        foreach (th[k]) begin
            wr(`CONV_CTRL_ONE_ADDR, 16'({th[k], 1'b0}));
            check(16'(low_input_threshold), 16'(th[k]));
        end
        wr(`CONV_CTRL_TWO_ADDR, 16'h8D01);
        rd(`CONV_CTRL_TWO_ADDR, 16'h8D01);
        wr(`CONV_CTRL_TWO_ADDR, 16'h8C86);
        rd(`CONV_CTRL_TWO_ADDR, 16'h8C86);
        wr(32'h5000_0086, 16'hFFFF);
        rd(32'h5000_0086, 16'h0000);
        rd(`CONV_CTRL_TWO_ADDR, 16'h8C86);
        // Regulator forces the top boost bit; stored bit survives
        wr(`CONV_CTRL_TWO_ADDR, 16'h0600);
        otpWanted <= 1'b1;
        repeat (8) @(posedge sys_clk);
        #1;
        check(16'(boost_output_code), 16'h0007);
        rd(`CONV_CTRL_TWO_ADDR, 16'h0E00);
        otpWanted <= 1'b0;
        repeat (8) @(posedge sys_clk);
        #1;
        check(16'(boost_output_code), 16'h0003);
        check(16'(useSlowIdleTrigger), 16'h0000);
        oscWanted <= 1'b0;
        repeat (8) @(posedge sys_clk);
        #1;
        check(16'(useSlowIdleTrigger), 16'h0001);
        oscWanted <= 1'b1;
        reset_and_defaults();
        summarize();
    end
    // Watchdog far beyond the roughly 120 cycles the tests need
    initial begin
        #(50 * 4000);
        numErrors++;
        summarize();
    end
endmodule // testbench
`default_nettype wire
